// ---- timer8_defines.svh ----
// Purpose: constants for the 8-bit dual compare timer
// Assumes: 8-bit counter, 3-bit mode and clock select fields
// Notes:   definitions only
`ifndef TIMER8_DEFINES_SVH
`define TIMER8_DEFINES_SVH
`define T8_BOTTOM      8'h00
`define T8_MAX         8'hff
`define T8_ZERO8       8'h00
// Waveform modes
`define T8_WGM_NORMAL  3'h0
`define T8_WGM_PCPWM   3'h1
`define T8_WGM_CTC     3'h2
`define T8_WGM_FAST    3'h3
`define T8_WGM_PCPWM_A 3'h5
`define T8_WGM_FAST_A  3'h7
// Clock select codes
`define T8_CS_STOP     3'h0
`define T8_CS_DIV1     3'h1
`define T8_CS_DIV8     3'h2
`define T8_CS_DIV64    3'h3
`define T8_CS_DIV256   3'h4
`define T8_CS_DIV1024  3'h5
`define T8_CS_EXT_FALL 3'h6
`define T8_CS_EXT_RISE 3'h7
// Prescaler tap positions
`define T8_PRE_W       10
`define T8_TAP8        2
`define T8_TAP64       5
`define T8_TAP256      7
`define T8_TAP1024     9
// Flag bit positions
`define T8_F_OVF       0
`define T8_F_CMPA      1
`define T8_F_CMPB      2
`endif

// ---- timer8_pkg.sv ----
// Purpose: shared types for the 8-bit dual compare timer
// Assumes: used with timer8_defines.svh
// Notes:   types only
package timer8_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] mode_t;
  typedef logic [1:0] com_t;
endpackage

// ---- timer8_tick_gen.sv ----
// Purpose: timer tick source, prescaled system clock or external pin edge
// Assumes: pin already synchronised by the caller
// Notes:   one-cycle enable pulses on one clock
`timescale 1ns/10ps
`include "timer8_defines.svh"
module timer8_tick_gen (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  // Control
  input  wire timer8_pkg::mode_t    clock_select,
  input  wire logic                 enable,
  input  wire logic                 pin_sync,
  // Tick out
  output logic                      timer_tick
);
  import timer8_pkg::*;
  logic [`T8_PRE_W-1:0] pre;
  logic [`T8_PRE_W-1:0] next_pre;
  logic                 pin_prev;
  logic                 next_pin_prev;
  logic                 next_tick;
  logic [`T8_PRE_W-1:0] pre_inc;

  // Prescaler count and tick choice
  always_comb begin
    pre_inc       = pre + `T8_PRE_W'(1);
    next_pre      = enable ? pre_inc : pre;
    next_pin_prev = pin_sync;
    next_tick     = 1'b0;
    if (enable) begin
      case (clock_select)
        `T8_CS_STOP:     next_tick = 1'b0;
        `T8_CS_DIV1:     next_tick = 1'b1;
        `T8_CS_DIV8:     next_tick = pre_inc[`T8_TAP8:0] == '0;
        `T8_CS_DIV64:    next_tick = pre_inc[`T8_TAP64:0] == '0;
        `T8_CS_DIV256:   next_tick = pre_inc[`T8_TAP256:0] == '0;
        `T8_CS_DIV1024:  next_tick = pre_inc[`T8_TAP1024:0] == '0;
        `T8_CS_EXT_FALL: next_tick = pin_prev & ~pin_sync;
        `T8_CS_EXT_RISE: next_tick = ~pin_prev & pin_sync;
        default:         next_tick = 1'b0;
      endcase
    end
  end

  // Registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pre        <= '0;
      pin_prev   <= 1'b0;
      timer_tick <= 1'b0;
    end else begin
      pre        <= next_pre;
      pin_prev   <= next_pin_prev;
      timer_tick <= next_tick;
    end
  end

  // No tick while stopped
  stop_quiet_a: assert property (@(posedge clock) disable iff (sys_rst) // see R4
    $past(clock_select) == `T8_CS_STOP |-> !timer_tick)
    else $error("tick while stopped");
endmodule

// ---- timer8_dual_compare_pwm.sv ----
// Purpose: 8-bit timer with two compare units, PWM and three event flags
// Assumes: CPU access arrives as write strobes with data on plain ports
// Notes:   flags set by hardware win over a same-cycle software clear
`timescale 1ns/10ps
`include "timer8_defines.svh"
// Operation
// R1: Counter and two compares are 8-bit
// R2: Bottom is 0x00, max is 0xFF
// R3: Top is 0xFF or compare A
// R4: Clock select zero stops the counter
// R5: Prescaled clock or external pin edge
// R6: Tick clears, increments or decrements by mode
// R7: CPU reads and writes counter any time
// R8: CPU counter write beats count or clear
// R9: Three-bit waveform mode picks the sequence
// R10: Overflow flag set per mode, interrupt capable
// R11: Flags readable together, each request masked
// R12: Match whenever counter equals compare value
// R13: Compare flag set on next tick
// R14: Interrupt service clears compare flag
// R15: Writing one clears a flag
// R16: Compares double-buffered only in PWM modes
// R17: Buffer copies at top or bottom only
// R18: CPU reaches buffer or active register
// R19: Force strobe acts on output only
// R20: Counter write blocks next tick's matches
// R21: Software avoids writing counter equal compare
// R22: Outputs from match, mode, compare mode
// R23: Power reduction bit low enables timer
// R24: Normal mode wraps, overflow at zero
// R25: Compare mode zero leaves output alone
// R26: Reset clears waveform output registers
// R27: Reset clears counter, compares, flags, select
module timer8_dual_compare_pwm (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  // Control fields
  input  wire timer8_pkg::mode_t    waveform_mode,
  input  wire timer8_pkg::mode_t    clock_select_in,
  input  wire logic                 clock_select_we,
  input  wire timer8_pkg::com_t     compare_output_mode_a,
  input  wire timer8_pkg::com_t     compare_output_mode_b,
  input  wire logic                 force_compare_strobe_a,
  input  wire logic                 force_compare_strobe_b,
  input  wire logic                 timer_power_reduce,
  // Counter and compare writes
  input  wire timer8_pkg::byte_t    wdata,
  input  wire logic                 count_we,
  input  wire logic                 compare_a_we,
  input  wire logic                 compare_b_we,
  // Flags and masks
  input  wire logic [2:0]           flag_clear_we,
  input  wire logic [2:0]           timer_mask_reg,
  input  wire logic [2:0]           irq_ack,
  // Pins
  input  wire logic                 external_count_pin,
  output logic                      wave_out_a,
  output logic                      wave_out_b,
  // Status
  output timer8_pkg::byte_t         count_value,
  output timer8_pkg::byte_t         compare_value_a,
  output timer8_pkg::byte_t         compare_value_b,
  output logic [2:0]                timer_flag_reg,
  output logic [2:0]                irq_req
);
  import timer8_pkg::*;
  logic      pin_s1, pin_s2;
  logic      timer_tick;
  mode_t     clock_select, next_clock_select;
  byte_t     next_count;
  byte_t     buf_a, buf_b, next_buf_a, next_buf_b;
  byte_t     act_a, act_b, next_act_a, next_act_b;
  logic      dir_down, next_dir_down;
  logic      block_match, next_block_match;
  logic [2:0] next_flags, next_irq;
  logic      next_wave_a, next_wave_b;
  logic      pwm_mode, fast_mode, pc_mode, top_is_a;
  byte_t     top;
  logic      at_bottom, at_max, at_top;
  logic      match_a, match_b;
  logic      ovf_evt, upd_point;
  byte_t     next_cv_a, next_cv_b;

  // Pin synchroniser
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
    end else begin
      pin_s1 <= external_count_pin;
      pin_s2 <= pin_s1;
    end
  end

  // Tick source
  timer8_tick_gen u_tick (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .clock_select (clock_select),
    .enable       (!timer_power_reduce), // see R23
    .pin_sync     (pin_s2),
    .timer_tick   (timer_tick)           // see R5
  );

  // Mode decode and extremes
  always_comb begin
    fast_mode = waveform_mode == `T8_WGM_FAST || waveform_mode == `T8_WGM_FAST_A;
    pc_mode   = waveform_mode == `T8_WGM_PCPWM || waveform_mode == `T8_WGM_PCPWM_A;
    pwm_mode  = fast_mode | pc_mode;
    top_is_a  = waveform_mode == `T8_WGM_CTC || waveform_mode[2]; // see R3, R9
    top       = top_is_a ? act_a : `T8_MAX;
    at_bottom = count_value == `T8_BOTTOM;                          // see R2
    at_max    = count_value == `T8_MAX;                             // see R2
    at_top    = count_value == top;
    match_a   = count_value == act_a && !block_match;               // see R12, R20
    match_b   = count_value == act_b && !block_match;               // see R12, R20
  end

  // Counter, direction and compare registers
  always_comb begin
    next_count       = count_value;
    next_dir_down    = dir_down;
    next_act_a       = act_a;
    next_act_b       = act_b;
    next_buf_a       = buf_a;
    next_buf_b       = buf_b;
    next_block_match = block_match;
    ovf_evt          = 1'b0;
    upd_point        = 1'b0;
    next_clock_select = clock_select_we ? clock_select_in : clock_select; // see R4
    if (timer_tick) begin
      next_block_match = 1'b0;
      if (pc_mode) begin
        if (at_top) next_dir_down = 1'b1;
        if (at_bottom) next_dir_down = 1'b0;
        if (at_top) begin
          next_count = count_value - 8'h01;                         // see R6
          upd_point  = 1'b1;                                        // see R17
        end else if (at_bottom) begin
          next_count = count_value + 8'h01;
          ovf_evt    = 1'b1;                                        // see R10
        end else begin
          next_count = dir_down ? count_value - 8'h01 : count_value + 8'h01;
        end
      end else if (at_top && top_is_a) begin
        next_count = `T8_BOTTOM;                                    // see R6
        ovf_evt    = fast_mode;
        upd_point  = 1'b1;
      end else begin
        next_count = count_value + 8'h01;                           // see R24
        ovf_evt    = at_max;                                        // see R10, R24
        upd_point  = at_max;
      end
      if (upd_point && pwm_mode) begin
        next_act_a = buf_a;                                         // see R16, R17
        next_act_b = buf_b;
      end
    end
    if (count_we) begin
      next_count       = wdata;                                     // see R7, R8
      next_block_match = 1'b1;                                      // see R20
    end
    if (compare_a_we) begin
      next_buf_a = wdata;                                           // see R18
      if (!pwm_mode) next_act_a = wdata;
    end
    if (compare_b_we) begin
      next_buf_b = wdata;
      if (!pwm_mode) next_act_b = wdata;
    end
    next_cv_a = pwm_mode ? next_buf_a : next_act_a;                 // see R1, R18
    next_cv_b = pwm_mode ? next_buf_b : next_act_b;
  end

  // Flags: hardware set beats clear
  always_comb begin
    logic [2:0] set_v;
    set_v = '0;
    set_v[`T8_F_OVF]  = ovf_evt;
    set_v[`T8_F_CMPA] = timer_tick & match_a;                       // see R13
    set_v[`T8_F_CMPB] = timer_tick & match_b;
    next_flags = (timer_flag_reg & ~flag_clear_we & ~irq_ack) | set_v; // see R14, R15
    next_irq   = next_flags & timer_mask_reg;                       // see R11
  end

  // Waveform generator
  always_comb begin
    next_wave_a = wave_out_a;
    next_wave_b = wave_out_b;
    if (!pwm_mode) begin
      if ((timer_tick && match_a) || force_compare_strobe_a) begin  // see R19, R22
        case (compare_output_mode_a)
          2'h1:    next_wave_a = ~wave_out_a;
          2'h2:    next_wave_a = 1'b0;
          2'h3:    next_wave_a = 1'b1;
          default: next_wave_a = wave_out_a;                        // see R25
        endcase
      end
      if ((timer_tick && match_b) || force_compare_strobe_b) begin
        case (compare_output_mode_b)
          2'h1:    next_wave_b = ~wave_out_b;
          2'h2:    next_wave_b = 1'b0;
          2'h3:    next_wave_b = 1'b1;
          default: next_wave_b = wave_out_b;
        endcase
      end
    end else if (timer_tick) begin
      if (compare_output_mode_a[1]) begin
        if (match_a) next_wave_a = pc_mode ? (dir_down ^ compare_output_mode_a[0])
                                           : compare_output_mode_a[0];
        else if (fast_mode && at_top) next_wave_a = ~compare_output_mode_a[0];
      end else if (compare_output_mode_a == 2'h1 && waveform_mode[2] && match_a) begin
        next_wave_a = ~wave_out_a;
      end
      if (compare_output_mode_b[1]) begin
        if (match_b) next_wave_b = pc_mode ? (dir_down ^ compare_output_mode_b[0])
                                           : compare_output_mode_b[0];
        else if (fast_mode && at_top) next_wave_b = ~compare_output_mode_b[0];
      end
    end
  end

  // State registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count_value     <= `T8_ZERO8;                                 // see R27
      act_a           <= `T8_ZERO8;
      act_b           <= `T8_ZERO8;
      buf_a           <= `T8_ZERO8;
      buf_b           <= `T8_ZERO8;
      compare_value_a <= `T8_ZERO8;
      compare_value_b <= `T8_ZERO8;
      clock_select    <= `T8_CS_STOP;
      dir_down        <= 1'b0;
      block_match     <= 1'b0;
      timer_flag_reg  <= '0;
      irq_req         <= '0;
      wave_out_a      <= 1'b0;                                      // see R26
      wave_out_b      <= 1'b0;
    end else begin
      count_value     <= next_count;
      act_a           <= next_act_a;
      act_b           <= next_act_b;
      buf_a           <= next_buf_a;
      buf_b           <= next_buf_b;
      compare_value_a <= next_cv_a;
      compare_value_b <= next_cv_b;
      clock_select    <= next_clock_select;
      dir_down        <= next_dir_down;
      block_match     <= next_block_match;
      timer_flag_reg  <= next_flags;
      irq_req         <= next_irq;
      wave_out_a      <= next_wave_a;
      wave_out_b      <= next_wave_b;
    end
  end

  // Checks; the tick lags the select by one cycle and the count by one more
  cpu_write_wins_a: assert property (@(posedge clock) disable iff (sys_rst) // see R8
    count_we |=> count_value == $past(wdata))
    else $error("counter write lost");
  stopped_hold_a: assert property (@(posedge clock) disable iff (sys_rst) // see R4
    $past(clock_select) == `T8_CS_STOP && !count_we |=> $stable(count_value))
    else $error("counter moved while stopped");
  normal_wrap_a: assert property (@(posedge clock) disable iff (sys_rst) // see R24
    waveform_mode == `T8_WGM_NORMAL && timer_tick && at_max && !count_we
    |=> count_value == `T8_BOTTOM && timer_flag_reg[`T8_F_OVF])
    else $error("normal wrap wrong");
  match_flag_a: assert property (@(posedge clock) disable iff (sys_rst) // see R13
    timer_tick && count_value == act_a && !block_match |=> timer_flag_reg[`T8_F_CMPA])
    else $error("compare flag a not set");
  block_after_write_a: assert property (@(posedge clock) disable iff (sys_rst) // see R20
    count_we ##1 (timer_tick && !timer_flag_reg[`T8_F_CMPA])
    |=> !timer_flag_reg[`T8_F_CMPA])
    else $error("match not blocked");
  clear_one_a: assert property (@(posedge clock) disable iff (sys_rst) // see R15
    flag_clear_we[`T8_F_CMPB] && !(timer_tick && match_b) |=> !timer_flag_reg[`T8_F_CMPB])
    else $error("flag b not cleared");
  irq_mask_a: assert property (@(posedge clock) disable iff (sys_rst) // see R11
    irq_req == (timer_flag_reg & $past(timer_mask_reg)))
    else $error("irq not masked");
  force_noflag_a: assert property (@(posedge clock) disable iff (sys_rst) // see R19
    force_compare_strobe_a && !timer_tick && !timer_flag_reg[`T8_F_CMPA]
    |=> !timer_flag_reg[`T8_F_CMPA])
    else $error("force set flag");
  pwm_buffer_a: assert property (@(posedge clock) disable iff (sys_rst) // see R17
    pwm_mode && !upd_point && !compare_a_we && $stable(waveform_mode) |=> $stable(act_a))
    else $error("active compare moved");
  power_off_a: assert property (@(posedge clock) disable iff (sys_rst) // see R23
    timer_power_reduce |=> !timer_tick)
    else $error("tick while powered down");
  cov_ovf_c: cover property (@(posedge clock) timer_flag_reg[`T8_F_OVF]);
  cov_ctc_c: cover property (@(posedge clock)
    waveform_mode == `T8_WGM_CTC && timer_tick && match_a);
  cov_pwm_c: cover property (@(posedge clock) pc_mode && timer_tick && at_top);
endmodule

// ---- timer8_dual_compare_pwm_tb.sv ----
// Purpose: self-checking bench for the 8-bit dual compare timer
// Assumes: outputs settle before the falling edge; inputs change there
// Notes:   driver queues expected values, a monitor compares them on time
`timescale 1ns/10ps
`include "timer8_defines.svh"
module timer8_dual_compare_pwm_tb;
  import timer8_pkg::*;
  typedef struct {int due; int sel; byte_t exp;} note_s;
  // Design ports
  logic       clock;
  logic       sys_rst;
  mode_t      waveform_mode;
  mode_t      clock_select_in;
  logic       clock_select_we;
  com_t       compare_output_mode_a;
  com_t       compare_output_mode_b;
  logic       force_compare_strobe_a;
  logic       force_compare_strobe_b;
  logic       timer_power_reduce;
  byte_t      wdata;
  logic       count_we;
  logic       compare_a_we;
  logic       compare_b_we;
  logic [2:0] flag_clear_we;
  logic [2:0] timer_mask_reg;
  logic [2:0] irq_ack;
  logic       external_count_pin;
  logic       wave_out_a;
  logic       wave_out_b;
  byte_t      count_value;
  byte_t      compare_value_a;
  byte_t      compare_value_b;
  logic [2:0] timer_flag_reg;
  logic [2:0] irq_req;
  // Bench state
  note_s      q[$];
  int         cyc = 0;
  int         bad_count = 0;
  int         n_checks = 0;
  int         seed = 32'h5ab6;
  byte_t      v;

  timer8_dual_compare_pwm i_timer8_dual_compare_pwm (.clock(clock), .sys_rst(sys_rst),
    .waveform_mode(waveform_mode), .clock_select_in(clock_select_in),
    .clock_select_we(clock_select_we), .compare_output_mode_a(compare_output_mode_a),
    .compare_output_mode_b(compare_output_mode_b),
    .force_compare_strobe_a(force_compare_strobe_a),
    .force_compare_strobe_b(force_compare_strobe_b), .timer_power_reduce(timer_power_reduce),
    .wdata(wdata), .count_we(count_we), .compare_a_we(compare_a_we),
    .compare_b_we(compare_b_we), .flag_clear_we(flag_clear_we),
    .timer_mask_reg(timer_mask_reg), .irq_ack(irq_ack),
    .external_count_pin(external_count_pin), .wave_out_a(wave_out_a),
    .wave_out_b(wave_out_b), .count_value(count_value), .compare_value_a(compare_value_a),
    .compare_value_b(compare_value_b), .timer_flag_reg(timer_flag_reg), .irq_req(irq_req));

  // Clock generator, 5 ns period
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Cycle counter for due times
  always @(posedge clock) begin
    cyc <= cyc + 1;
  end

  // Selects one output as a byte
  function automatic byte_t probe(int sel);
    case (sel)
      0: probe = count_value;
      1: probe = compare_value_a;
      2: probe = compare_value_b;
      3: probe = {5'h00, timer_flag_reg};
      4: probe = {5'h00, irq_req};
      default: probe = {6'h00, wave_out_b, wave_out_a};
    endcase
  endfunction

  // Single comparison point
  task automatic check(byte_t seen, byte_t exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Queue an expectation dly cycles ahead
  task automatic note(int dly, int sel, byte_t exp);
    q.push_back('{cyc + dly, sel, exp});
  endtask

  // Monitor takes due notes off the queue
  always @(negedge clock) begin
    while (q.size() > 0 && q[0].due <= cyc) begin
      if (q[0].due == cyc) check(probe(q[0].sel), q[0].exp);
      void'(q.pop_front());
    end
  end

  task automatic cyc_n(int n);
    repeat (n) @(negedge clock);
  endtask

  // Write pulse: 0 counter, 1 compare A, 2 compare B
  task automatic wr(int sel, byte_t val);
    @(negedge clock);
    wdata = val;
    count_we = (sel == 0);
    compare_a_we = (sel == 1);
    compare_b_we = (sel == 2);
    note(1, sel, val);
    @(negedge clock);
    count_we = 1'b0;
    compare_a_we = 1'b0;
    compare_b_we = 1'b0;
  endtask

  task automatic set_cs(mode_t cs);
    @(negedge clock);
    clock_select_in = cs;
    clock_select_we = 1'b1;
    @(negedge clock);
    clock_select_we = 1'b0;
  endtask

  // Flag clear or service pulse, then expected flags
  task automatic clr(logic [2:0] fc, logic [2:0] ack, byte_t exp);
    @(negedge clock);
    flag_clear_we = fc;
    irq_ack = ack;
    note(1, 3, exp);
    @(negedge clock);
    flag_clear_we = 3'h0;
    irq_ack = 3'h0;
  endtask

  task automatic force_both;
    @(negedge clock);
    force_compare_strobe_a = 1'b1;
    force_compare_strobe_b = 1'b1;
    @(negedge clock);
    force_compare_strobe_a = 1'b0;
    force_compare_strobe_b = 1'b0;
  endtask

  // Bounded wait on masked output
  task automatic wait_for(int sel, byte_t mask, byte_t val, int bound);
    int k;
    k = 0;
    while ((probe(sel) & mask) !== val && k < bound) begin
      @(negedge clock);
      k++;
    end
    if ((probe(sel) & mask) !== val) begin
      check(probe(sel) & mask, val);
      end_sim();
    end
  endtask

  // Overall watchdog
  initial begin
    repeat (60000) @(posedge clock);
    bad_count++;
    end_sim();
  end

  // Main sequence
  initial begin
    {sys_rst, clock_select_we, force_compare_strobe_a, force_compare_strobe_b} = 4'hf;
    {clock_select_we, force_compare_strobe_a, force_compare_strobe_b} = 3'h0;
    {timer_power_reduce, count_we, compare_a_we, compare_b_we, external_count_pin} = 5'h00;
    {flag_clear_we, timer_mask_reg, irq_ack} = 9'h000;
    {compare_output_mode_a, compare_output_mode_b} = 4'h0;
    waveform_mode = `T8_WGM_NORMAL;
    clock_select_in = `T8_CS_STOP;
    wdata = 8'h00;
    repeat (20) @(negedge clock);
    sys_rst = 1'b0;
    for (int s = 0; s < 6; s++) note(1, s, 8'h00);
    cyc_n(1);
    // Random readback of all three registers
    for (int i = 0; i < 3; i++) begin
      v = byte_t'($random(seed));
      wr(i, v);
    end
    // Normal mode wrap and overflow
    wr(1, 8'h10);
    wr(2, 8'h80);
    wr(0, 8'hfd);
    timer_mask_reg = 3'h1;
    set_cs(`T8_CS_DIV1);
    wait_for(0, 8'hff, 8'h00, 20);
    check(probe(3), 8'h01);
    note(1, 4, 8'h01);
    set_cs(`T8_CS_STOP);
    cyc_n(3);
    v = count_value;
    note(5, 0, v);
    cyc_n(5);
    clr(3'h1, 3'h0, 8'h00);
    // Compare A match sets flag on next tick
    wr(0, 8'h0c);
    set_cs(`T8_CS_DIV1);
    wait_for(3, 8'h02, 8'h02, 20);
    check(count_value, 8'h11);
    set_cs(`T8_CS_STOP);
    cyc_n(3);
    clr(3'h0, 3'h2, 8'h00);
    // Counter write blocks the next match
    wr(0, 8'h10);
    set_cs(`T8_CS_DIV1);
    cyc_n(4);
    set_cs(`T8_CS_STOP);
    cyc_n(3);
    note(1, 3, 8'h00);
    cyc_n(1);
    // CPU writes win over running ticks
    set_cs(`T8_CS_DIV1);
    for (int i = 0; i < 4; i++) begin
      v = byte_t'($random(seed));
      if (v == 8'h10 || v == 8'h80) v = 8'h20;
      wr(0, v);
    end
    // Power reduction freezes the count
    timer_power_reduce = 1'b1;
    cyc_n(3);
    v = count_value;
    note(6, 0, v);
    cyc_n(6);
    timer_power_reduce = 1'b0;
    wait_for(0, 8'hff, v + 8'h01, 8);
    set_cs(`T8_CS_STOP);
    cyc_n(3);
    // Force strobes in normal mode
    clr(3'h7, 3'h0, 8'h00);
    compare_output_mode_a = 2'h1;
    compare_output_mode_b = 2'h1;
    v = count_value;
    force_both();
    wait_for(5, 8'h03, 8'h03, 4);
    note(1, 3, 8'h00);
    note(1, 0, v);
    cyc_n(1);
    compare_output_mode_a = 2'h0;
    compare_output_mode_b = 2'h0;
    force_both();
    note(3, 5, 8'h03);
    cyc_n(4);
    // Fast PWM: compare write held in buffer until top
    waveform_mode = `T8_WGM_FAST;
    wr(1, 8'h50);
    wr(0, 8'h0c);
    set_cs(`T8_CS_DIV1);
    wait_for(3, 8'h02, 8'h02, 20);
    check(count_value, 8'h11);
    @(negedge clock);
    flag_clear_we = 3'h2;
    @(negedge clock);
    flag_clear_we = 3'h0;
    wait_for(3, 8'h02, 8'h02, 600);
    check(count_value, 8'h51);
    set_cs(`T8_CS_STOP);
    cyc_n(3);
    // External pin, rising then falling edge
    waveform_mode = `T8_WGM_NORMAL;
    for (int e = 0; e < 2; e++) begin
      wr(0, 8'h00);
      set_cs(e == 0 ? `T8_CS_EXT_RISE : `T8_CS_EXT_FALL);
      repeat (3) begin
        external_count_pin = 1'b1;
        cyc_n(8);
        external_count_pin = 1'b0;
        cyc_n(8);
      end
      note(1, 0, 8'h03);
      cyc_n(1);
      set_cs(`T8_CS_STOP);
    end
    // CTC: compare A is top, output A toggles on the match
    waveform_mode = `T8_WGM_CTC;
    compare_output_mode_a = 2'h1;
    clr(3'h7, 3'h0, 8'h00);
    wr(1, 8'h05);
    wr(0, 8'h00);
    set_cs(`T8_CS_DIV1);
    wait_for(3, 8'h02, 8'h02, 20);
    check(count_value, 8'h00);
    check(probe(3), 8'h02);
    check(probe(5) & 8'h01, 8'h00);
    set_cs(`T8_CS_STOP);
    cyc_n(2);
    end_sim();
  end
endmodule
